// [hw/pspc_pkg.sv]
// package: processor state and privilege control constants and types
package pspc_pkg;

    // ------------------------------------------------------------
    // status word layout
    // ------------------------------------------------------------
    localparam int    SW_SUPER_BIT  = 13;
    localparam int    SW_TRACE_BIT  = 15;
    localparam int    SW_IMASK_LSB  = 8;
    localparam int    IMASK_WIDTH   = 3;
    localparam logic [15:0] SW_RESET = 16'h2700;
    localparam logic [2:0] IRQ_NMI_LEVEL = 3'h7;

    // ------------------------------------------------------------
    // timing counts in cycles of mclk
    // ------------------------------------------------------------
    localparam int    VEC_FETCH_CYC = 2;
    localparam int    STACK_CYC     = 2;
    localparam int    REFILL_CYC    = 2;
    localparam int    LP_PHASE_CYC  = 2;
    localparam int    CNT_WIDTH     = 4;

    // ------------------------------------------------------------
    // operating state and substeps
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PSPC_NORMAL    = 2'b00,
        PSPC_EXCEPTION = 2'b01,
        PSPC_LOWPOWER  = 2'b10,
        PSPC_HALTED    = 2'b11
    } pspc_state_t;

    typedef enum logic [1:0] {
        EXC_VECTOR = 2'b00,
        EXC_STACK  = 2'b01,
        EXC_REFILL = 2'b10,
        EXC_HANDLR = 2'b11
    } pspc_exc_step_t;

    typedef enum logic [3:0] {
        CAUSE_NONE      = 4'h0,
        CAUSE_ACCESS    = 4'h1,
        CAUSE_ADDRESS   = 4'h2,
        CAUSE_PRIVILEGE = 4'h3,
        CAUSE_TRACE     = 4'h4,
        CAUSE_TRAP      = 4'h5,
        CAUSE_INSTR     = 4'h6,
        CAUSE_INTERRUPT = 4'h7
    } pspc_cause_t;

    // instruction issued by the execute pipeline for a privilege check
    typedef struct packed {
        logic valid;
        logic is_stop;
        logic is_lowpower;
        logic is_reset;
        logic touches_sw;
        logic is_trap;
        logic is_exc_instr;
        logic writes_sw;
        logic [15:0] sw_value;
    } pspc_instr_t;

    // register access request from the execute pipeline
    typedef struct packed {
        logic valid;
        logic supervisor_only;
    } pspc_regreq_t;

    // bus cycle qualification towards the bus controller
    typedef struct packed {
        logic supervisor;
        logic allowed;
    } pspc_busq_t;

endpackage

// [hw/pspc_exc_seq.sv]
// exception processing sequencer: vector fetch, stacking, pipeline refill
`timescale 1ns/1ps
module pspc_exc_seq (
    input  wire logic                     mclk,
    input  wire logic                     resetn,
    input  wire logic                     start,
    input  wire logic                     handler_started,
    output logic                          busy,
    output logic                          push_sw,
    output pspc_pkg::pspc_exc_step_t      step,
    output logic                          done
);
    import pspc_pkg::*;

    pspc_exc_step_t        step_q;
    pspc_exc_step_t        step_d;
    logic                  busy_q;
    logic [CNT_WIDTH-1:0]  cnt_q;
    logic [CNT_WIDTH-1:0]  cnt_d;
    logic                  busy_d;
    logic                  cnt_zero;
    logic                  finish;

    function automatic logic [CNT_WIDTH-1:0] step_len(input pspc_exc_step_t s);
        case (s)
            EXC_VECTOR: step_len = CNT_WIDTH'(VEC_FETCH_CYC - 1);
            EXC_STACK:  step_len = CNT_WIDTH'(STACK_CYC - 1);
            EXC_REFILL: step_len = CNT_WIDTH'(REFILL_CYC - 1);
            default:    step_len = '0;
        endcase
    endfunction

    assign cnt_zero = (cnt_q == '0);
    // complete only once the first handler instruction begins executing
    assign finish   = busy_q && (step_q == EXC_HANDLR) && handler_started; // [RULE2]

    always_comb begin
        step_d = step_q;
        cnt_d  = cnt_q;
        busy_d = busy_q;
        if (start && !busy_q) begin
            busy_d = 1'b1;
            step_d = EXC_VECTOR;
            cnt_d  = step_len(EXC_VECTOR);
        end else if (finish) begin
            // park on the first step so an idle sequencer never looks finished
            busy_d = 1'b0;
            step_d = EXC_VECTOR;
        end else if (busy_q && step_q != EXC_HANDLR) begin
            if (!cnt_zero) begin
                cnt_d = cnt_q - 1'b1;
            end else begin
                case (step_q)
                    EXC_VECTOR: step_d = EXC_STACK;
                    EXC_STACK:  step_d = EXC_REFILL;
                    EXC_REFILL: step_d = EXC_HANDLR;
                    default:    step_d = EXC_HANDLR;
                endcase
                cnt_d = step_len(step_d);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            step_q <= EXC_VECTOR;
            cnt_q  <= '0;
            busy_q <= 1'b0;
        end else begin
            step_q <= step_d;
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
        end
    end

    assign busy    = busy_q;
    assign step    = step_q;
    // status word goes onto the supervisor stack in the first stacking cycle
    assign push_sw = busy_q && (step_q == EXC_STACK) && (cnt_q == step_len(EXC_STACK)); // [RULE13]
    assign done    = finish;

endmodule

// [hw/pspc_core.sv]
// top: processor operating state and supervisor/user privilege control
//
// Behaviour
// [RULE1] always exactly one of four operating states
// [RULE2] exception: vector, stacking, refill, until handler runs
// [RULE3] internal and external conditions start exception processing
// [RULE4] low-power halt: four phases, exit reset/nonmasked interrupt
// [RULE5] access/address error during exception halts processor
// [RULE6] halted state left only by external reset
// [RULE7] stop: normal state without bus cycles, not halted
// [RULE8] supervisor bit selects privilege, qualifies address space
// [RULE9] user mode reaches only user registers
// [RULE10] stop and reset instructions supervisor only
// [RULE11] status word supervisor bit access is privileged
// [RULE12] traps give user code entry to supervisor
// [RULE13] exception entry pushes status word, sets supervisor
// [RULE14] bus cycles tagged supervisor/user; exception cycles supervisor
// [RULE15] user privileged instruction raises privilege violation
`timescale 1ns/1ps
module pspc_core (
    input  wire logic                  mclk,
    input  wire logic                  resetn,
    input  wire pspc_pkg::pspc_instr_t instr,
    input  wire pspc_pkg::pspc_regreq_t reg_req,
    input  wire logic                  trace_event,
    input  wire logic                  access_error,
    input  wire logic                  address_error,
    input  wire logic [2:0]            irq_level,
    input  wire logic                  interrupt_wake,
    input  wire logic                  handler_started,
    output pspc_pkg::pspc_state_t      proc_state,
    output logic [15:0]                processor_status_word,
    output pspc_pkg::pspc_busq_t       bus_qual,
    output logic                       reg_grant,
    output logic                       instr_grant,
    output logic                       stopped,
    output logic [1:0]                 lp_phase,
    output pspc_pkg::pspc_cause_t      exc_cause,
    output logic                       push_sw,
    output logic [15:0]                pushed_sw,
    output pspc_pkg::pspc_exc_step_t   exc_step,
    output logic                       halted
);
    import pspc_pkg::*;

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    pspc_state_t           state_q;
    pspc_state_t           state_d;
    logic [15:0]           sw_q;
    logic [15:0]           sw_d;
    logic                  stop_q;
    logic                  stop_d;
    logic [1:0]            phase_q;
    logic [1:0]            phase_d;
    logic [CNT_WIDTH-1:0]  lp_cnt_q;
    logic [CNT_WIDTH-1:0]  lp_cnt_d;
    pspc_cause_t           cause_q;
    pspc_cause_t           cause_d;
    logic [15:0]           pushed_q;
    logic [15:0]           pushed_d;
    logic [2:0]            irq_s1_q;
    logic [2:0]            irq_s2_q;
    logic                  wake_s1_q;
    logic                  wake_s2_q;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire  super_mode   = sw_q[SW_SUPER_BIT]; // [RULE8]
    wire  [2:0] imask  = sw_q[SW_IMASK_LSB +: IMASK_WIDTH];
    wire  irq_pending  = (irq_s2_q == IRQ_NMI_LEVEL) || (irq_s2_q > imask);
    wire  in_normal    = (state_q == PSPC_NORMAL);
    wire  instr_priv   = instr.is_stop || instr.is_lowpower || instr.is_reset || instr.touches_sw; // [RULE10] [RULE11]
    wire  priv_viol    = in_normal && !stop_q && instr.valid && instr_priv && !super_mode; // [RULE15]
    wire  reg_viol     = in_normal && !stop_q && reg_req.valid && reg_req.supervisor_only && !super_mode; // [RULE9]
    wire  instr_ok     = in_normal && !stop_q && instr.valid && !priv_viol;
    wire  int_exc      = in_normal && !stop_q && (trace_event || (instr_ok && (instr.is_trap || instr.is_exc_instr)));
    wire  any_error    = access_error || address_error;
    wire  seq_busy;
    wire  seq_done;
    wire  seq_push;
    wire  ext_exc      = in_normal && (any_error || irq_pending); // [RULE3]
    wire  stop_wake    = stop_q && irq_pending;
    wire  enter_exc    = priv_viol || reg_viol || int_exc || ext_exc; // [RULE3]
    wire  lp_wake      = (state_q == PSPC_LOWPOWER) && wake_s2_q && irq_pending; // [RULE4]
    wire  lp_cnt_zero  = (lp_cnt_q == '0);

    // external interrupt level and wake come from outside the clock domain
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            irq_s1_q  <= 3'h0;
            irq_s2_q  <= 3'h0;
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
        end else begin
            irq_s1_q  <= irq_level;
            irq_s2_q  <= irq_s1_q;
            wake_s1_q <= interrupt_wake;
            wake_s2_q <= wake_s1_q;
        end
    end

    function automatic pspc_cause_t pick_cause(input logic acc, input logic adr, input logic pv,
                                               input logic trc, input logic trp);
        if (acc)
            pick_cause = CAUSE_ACCESS;
        else if (adr)
            pick_cause = CAUSE_ADDRESS;
        else if (pv)
            pick_cause = CAUSE_PRIVILEGE;
        else if (trc)
            pick_cause = CAUSE_TRACE;
        else if (trp)
            pick_cause = CAUSE_TRAP;
        else
            pick_cause = CAUSE_INTERRUPT;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_d  = state_q;
        sw_d     = sw_q;
        stop_d   = stop_q;
        phase_d  = phase_q;
        lp_cnt_d = lp_cnt_q;
        cause_d  = cause_q;
        pushed_d = pushed_q;
        case (state_q) // [RULE1]
            PSPC_NORMAL: begin
                if (enter_exc || stop_wake) begin
                    state_d = PSPC_EXCEPTION;
                    stop_d  = 1'b0;
                    cause_d = pick_cause(access_error, address_error, priv_viol || reg_viol,
                                         trace_event, instr.is_trap); // [RULE12]
                    if (instr_ok && instr.is_exc_instr && !instr.is_trap && !trace_event && !any_error)
                        cause_d = CAUSE_INSTR;
                    pushed_d = sw_q;
                    // supervisor forced for the whole exception
                    sw_d[SW_SUPER_BIT] = 1'b1; // [RULE13]
                    sw_d[SW_TRACE_BIT] = 1'b0;
                end else if (instr_ok && instr.is_lowpower) begin
                    state_d  = PSPC_LOWPOWER; // [RULE4]
                    phase_d  = 2'b00;
                    lp_cnt_d = CNT_WIDTH'(LP_PHASE_CYC - 1);
                    if (instr.writes_sw)
                        sw_d = instr.sw_value;
                end else if (instr_ok && instr.is_stop) begin
                    stop_d = 1'b1; // [RULE7]
                    if (instr.writes_sw)
                        sw_d = instr.sw_value;
                end else if (instr_ok && instr.writes_sw) begin
                    sw_d = instr.sw_value; // [RULE11]
                end
            end
            PSPC_EXCEPTION: begin
                // no state saved on a nested fault: the machine just stops
                if (any_error) begin
                    state_d = PSPC_HALTED; // [RULE5]
                end else if (seq_done) begin
                    state_d = PSPC_NORMAL; // [RULE2]
                end
            end
            PSPC_LOWPOWER: begin
                if (lp_wake) begin
                    state_d = PSPC_EXCEPTION;
                    cause_d = CAUSE_INTERRUPT;
                    pushed_d = sw_q;
                    sw_d[SW_SUPER_BIT] = 1'b1; // [RULE13]
                end else if (phase_q != 2'b11) begin
                    // walk the four entry phases, then sit quiet
                    if (lp_cnt_zero) begin
                        phase_d  = phase_q + 2'b01; // [RULE4]
                        lp_cnt_d = CNT_WIDTH'(LP_PHASE_CYC - 1);
                    end else begin
                        lp_cnt_d = lp_cnt_q - 1'b1;
                    end
                end
            end
            PSPC_HALTED: begin
                state_d = PSPC_HALTED; // [RULE6]
            end
            default: begin
                state_d = PSPC_HALTED;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state_q  <= PSPC_EXCEPTION;
            sw_q     <= SW_RESET;
            stop_q   <= 1'b0;
            phase_q  <= 2'b00;
            lp_cnt_q <= '0;
            cause_q  <= CAUSE_NONE;
            pushed_q <= 16'h0000;
        end else begin
            state_q  <= state_d;
            sw_q     <= sw_d;
            stop_q   <= stop_d;
            phase_q  <= phase_d;
            lp_cnt_q <= lp_cnt_d;
            cause_q  <= cause_d;
            pushed_q <= pushed_d;
        end
    end

    // ------------------------------------------------------------
    // exception sequencer
    // ------------------------------------------------------------
    // reset itself is handled as an exception, hence the reset state
    logic start_q;
    always_ff @(posedge mclk) begin
        if (!resetn)
            start_q <= 1'b1;
        else
            start_q <= (state_d == PSPC_EXCEPTION) && (state_q != PSPC_EXCEPTION);
    end

    pspc_exc_seq u_seq (
        .mclk            (mclk),
        .resetn          (resetn),
        .start           (start_q && state_q == PSPC_EXCEPTION && !seq_busy),
        .handler_started (handler_started),
        .busy            (seq_busy),
        .push_sw         (seq_push),
        .step            (exc_step),
        .done            (seq_done)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign proc_state            = state_q;
    assign processor_status_word = sw_q;
    assign bus_qual.supervisor   = super_mode || (state_q == PSPC_EXCEPTION); // [RULE14]
    // no bus traffic while stopped, quiescent or halted
    assign bus_qual.allowed      = (in_normal && !stop_q) || (state_q == PSPC_EXCEPTION); // [RULE7]
    assign reg_grant             = reg_req.valid && in_normal && !stop_q && !reg_viol; // [RULE9]
    assign instr_grant           = instr_ok; // [RULE15]
    assign stopped               = stop_q;
    assign lp_phase              = phase_q;
    assign exc_cause             = cause_q;
    assign push_sw               = seq_push && (state_q == PSPC_EXCEPTION); // [RULE13]
    assign pushed_sw             = pushed_q;
    assign halted                = (state_q == PSPC_HALTED); // [RULE6]

endmodule

// [testbench/pspc_core_sva.sv]
// checker: operating state and privilege assertions on the core ports
`timescale 1ns/1ps
module pspc_core_sva (
    input wire logic                     mclk,
    input wire logic                     resetn,
    input wire pspc_pkg::pspc_instr_t    instr,
    input wire pspc_pkg::pspc_regreq_t   reg_req,
    input wire logic                     trace_event,
    input wire logic                     access_error,
    input wire logic                     address_error,
    input wire logic [2:0]               irq_level,
    input wire logic                     interrupt_wake,
    input wire logic                     handler_started,
    input wire pspc_pkg::pspc_state_t    proc_state,
    input wire logic [15:0]              processor_status_word,
    input wire pspc_pkg::pspc_busq_t     bus_qual,
    input wire logic                     reg_grant,
    input wire logic                     instr_grant,
    input wire logic                     stopped,
    input wire logic [1:0]               lp_phase,
    input wire pspc_pkg::pspc_cause_t    exc_cause,
    input wire logic                     push_sw,
    input wire logic [15:0]              pushed_sw,
    input wire pspc_pkg::pspc_exc_step_t exc_step,
    input wire logic                     halted
);
    import pspc_pkg::*;
    logic user_m;
    logic priv_op;
    assign user_m  = !processor_status_word[SW_SUPER_BIT];
    assign priv_op = instr.is_stop || instr.is_lowpower || instr.is_reset || instr.touches_sw;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    property p_halt_on_err;
        proc_state == PSPC_EXCEPTION && (access_error || address_error) |=> halted && proc_state == PSPC_HALTED;
    endproperty
    a_halt_on_err: assert property (p_halt_on_err) else $error("error in exception did not halt");
    property p_halt_holds;
        halted |=> halted;
    endproperty
    a_halt_holds: assert property (p_halt_holds) else $error("halted state left without reset");
    property p_priv_refused;
        proc_state == PSPC_NORMAL && !stopped && instr.valid && priv_op && user_m && !access_error && !address_error
            |-> !instr_grant ##1 (proc_state == PSPC_EXCEPTION && exc_cause == CAUSE_PRIVILEGE);
    endproperty
    a_priv_refused: assert property (p_priv_refused) else $error("user privileged op not refused");
    property p_entry_super;
        $rose(proc_state == PSPC_EXCEPTION) |-> processor_status_word[SW_SUPER_BIT];
    endproperty
    a_entry_super: assert property (p_entry_super) else $error("exception entry not supervisor");
    property p_push_in_stack;
        push_sw |-> exc_step == EXC_STACK && proc_state == PSPC_EXCEPTION;
    endproperty
    a_push_in_stack: assert property (p_push_in_stack) else $error("push outside stacking step");
    property p_stop_bus;
        stopped |-> proc_state == PSPC_NORMAL && !bus_qual.allowed && !halted;
    endproperty
    a_stop_bus: assert property (p_stop_bus) else $error("stop condition wrong");
    property p_lp_phase;
        $rose(proc_state == PSPC_LOWPOWER) ##2 (proc_state == PSPC_LOWPOWER) |-> lp_phase == 2'h1;
    endproperty
    a_lp_phase: assert property (p_lp_phase) else $error("low power phase not advancing");
    property p_bus_user;
        proc_state == PSPC_NORMAL |-> bus_qual.supervisor == processor_status_word[SW_SUPER_BIT];
    endproperty
    a_bus_user: assert property (p_bus_user) else $error("bus space tag differs from status");
    property p_bus_exc;
        proc_state == PSPC_EXCEPTION |-> bus_qual.supervisor;
    endproperty
    a_bus_exc: assert property (p_bus_exc) else $error("exception cycle not supervisor");
    property p_reg_user;
        reg_req.valid && reg_req.supervisor_only && user_m |-> !reg_grant;
    endproperty
    a_reg_user: assert property (p_reg_user) else $error("user reached supervisor register");
    c_halt: cover property (proc_state == PSPC_HALTED);
    c_lowpower: cover property (proc_state == PSPC_LOWPOWER && lp_phase == 2'h3);
    c_stop: cover property (stopped);
endmodule

// [testbench/pspc_ext_model.sv]
// partner model: interrupt sources, system reset and bus error returns
`timescale 1ns/1ps
module pspc_ext_model (
    input  wire logic  mclk,
    output logic       resetn,
    output logic [2:0] irq_level,
    output logic       interrupt_wake,
    output logic       access_error,
    output logic       address_error
);
    initial begin
        resetn = 1'b0;
        irq_level = 3'h0;
        interrupt_wake = 1'b0;
        access_error = 1'b0;
        address_error = 1'b0;
    end
    // ------------------------------------------------------------
    // commands, called on a falling edge
    // ------------------------------------------------------------
    // the system is the only way out of halted
    task automatic set_reset(input logic on);
        resetn = !on;
    endtask
    task automatic irq(input logic [2:0] l);
        irq_level = l;
    endtask
    task automatic wake(input logic w);
        interrupt_wake = w;
    endtask
    // error returns are one-cycle pulses
    task automatic acc_err;
        access_error = 1'b1;
        @(negedge mclk);
        access_error = 1'b0;
    endtask
    task automatic addr_err;
        address_error = 1'b1;
        @(negedge mclk);
        address_error = 1'b0;
    endtask
endmodule

// [testbench/pspc_core_tb_top.sv]
// testbench: operating state and privilege scenarios for the core
`timescale 1ns/1ps
module pspc_core_tb_top;
    import pspc_pkg::*;
    logic           mclk = 1'b0;
    wire logic      resetn;
    pspc_instr_t    instr;
    pspc_regreq_t   reg_req;
    logic           trace_event;
    logic           handler_started;
    wire logic [2:0] irq_level;
    wire logic      interrupt_wake;
    wire logic      access_error;
    wire logic      address_error;
    pspc_state_t    proc_state;
    logic [15:0]    processor_status_word;
    pspc_busq_t     bus_qual;
    logic           reg_grant;
    logic           instr_grant;
    logic           stopped;
    logic [1:0]     lp_phase;
    pspc_cause_t    exc_cause;
    logic           push_sw;
    logic [15:0]    pushed_sw;
    pspc_exc_step_t exc_step;
    logic           halted;
    logic [15:0]    last_push;
    int             miscompares = 0;
    int             n_compared = 0;
    always #12.5 mclk = ~mclk;
    always @(negedge mclk) if (push_sw === 1'b1) last_push = pushed_sw;
    pspc_core dut (.*);
    pspc_ext_model ext (.*);
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic issue(input pspc_instr_t v, output logic g);
        instr = v;
        #1 g = instr_grant;
        cyc(1);
        instr = '0;
    endtask
    task automatic wait_state(input pspc_state_t s);
        for (int i = 0; i < 20 && proc_state !== s; i++) cyc(1);
        chk("proc_state", 16'(proc_state), 16'(s));
    endtask
    task automatic finish_exc;
        for (int i = 0; i < 20 && exc_step !== EXC_HANDLR; i++) cyc(1);
        chk("exc_step", 16'(exc_step), 16'(EXC_HANDLR));
        chk("state_in_handler_wait", 16'(proc_state), 16'(PSPC_EXCEPTION));
        handler_started = 1'b1;
        cyc(1);
        handler_started = 1'b0;
        chk("state_after_handler", 16'(proc_state), 16'(PSPC_NORMAL));
    endtask
    task automatic set_sw(input logic [15:0] v);
        logic g;
        issue({1'b1, 7'h09, v}, g);
        chk("sw_write_grant", 16'(g), 16'h0001);
        chk("sw_value", processor_status_word, v);
        chk("bus_space", 16'(bus_qual.supervisor), 16'(v[SW_SUPER_BIT]));
    endtask
    task automatic exc_entry(input pspc_cause_t c, input logic [15:0] old_sw);
        chk("exc_state", 16'(proc_state), 16'(PSPC_EXCEPTION));
        chk("exc_cause", 16'(exc_cause), 16'(c));
        chk("exc_super", 16'(processor_status_word[SW_SUPER_BIT]), 16'h0001);
        chk("exc_bus", 16'(bus_qual.supervisor), 16'h0001);
        finish_exc;
        chk("pushed_sw", last_push, old_sw);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        instr = '0;
        reg_req = '0;
        trace_event = 1'b0;
        handler_started = 1'b0;
        ext.set_reset(1'b1);
        cyc(12);
        chk("reset_state", 16'(proc_state), 16'(PSPC_EXCEPTION));
        chk("reset_sw", processor_status_word, SW_RESET);
        ext.set_reset(1'b0);
        finish_exc;
        $display("test reset done");
    endtask
    task automatic t_priv;
        logic [6:0] kinds [4] = '{7'h40, 7'h20, 7'h10, 7'h08};
        logic g;
        for (int k = 0; k < 5; k++) begin
            set_sw(16'h0000);
            if (k == 4) begin
                reg_req = '{1'b1, 1'b0};
                #1 chk("reg_user", 16'(reg_grant), 16'h0001);
                reg_req = '{1'b1, 1'b1};
                #1 chk("reg_super", 16'(reg_grant), 16'h0000);
                cyc(1);
                reg_req = '0;
            end else begin
                issue({1'b1, kinds[k], 16'h0000}, g);
                chk("priv_grant", 16'(g), 16'h0000);
            end
            exc_entry(CAUSE_PRIVILEGE, 16'h0000);
        end
        $display("test privilege done");
    endtask
    task automatic t_internal;
        logic g;
        set_sw(16'h0000);
        issue({1'b1, 7'h04, 16'h0000}, g);
        exc_entry(CAUSE_TRAP, 16'h0000);
        set_sw(16'h0000);
        issue({1'b1, 7'h02, 16'h0000}, g);
        exc_entry(CAUSE_INSTR, 16'h0000);
        set_sw(16'h0000);
        trace_event = 1'b1;
        cyc(1);
        trace_event = 1'b0;
        exc_entry(CAUSE_TRACE, 16'h0000);
        $display("test internal done");
    endtask
    task automatic t_stop;
        logic g;
        set_sw(16'h2000);
        issue({1'b1, 7'h40, 16'h0000}, g);
        chk("stop_grant", 16'(g), 16'h0001);
        cyc(4);
        chk("stopped", 16'(stopped), 16'h0001);
        chk("stop_state", 16'(proc_state), 16'(PSPC_NORMAL));
        chk("stop_no_bus", 16'(bus_qual.allowed), 16'h0000);
        ext.irq(IRQ_NMI_LEVEL);
        wait_state(PSPC_EXCEPTION);
        ext.irq(3'h0);
        chk("stop_cleared", 16'(stopped), 16'h0000);
        exc_entry(CAUSE_INTERRUPT, 16'h2000);
        $display("test stop done");
    endtask
    task automatic t_lowpower;
        logic g;
        set_sw(16'h2000);
        issue({1'b1, 7'h20, 16'h0000}, g);
        chk("lp_state", 16'(proc_state), 16'(PSPC_LOWPOWER));
        cyc(8);
        chk("lp_phase", 16'(lp_phase), 16'h0003);
        // an interrupt alone must not wake it
        ext.irq(IRQ_NMI_LEVEL);
        cyc(6);
        chk("lp_quiet", 16'(proc_state), 16'(PSPC_LOWPOWER));
        ext.wake(1'b1);
        wait_state(PSPC_EXCEPTION);
        ext.irq(3'h0);
        ext.wake(1'b0);
        exc_entry(CAUSE_INTERRUPT, 16'h2000);
        $display("test lowpower done");
    endtask
    task automatic t_halt;
        logic g;
        for (int k = 0; k < 2; k++) begin
            issue({1'b1, 7'h04, 16'h0000}, g);
            if (k == 0) ext.acc_err();
            else ext.addr_err();
            chk("halted", 16'(halted), 16'h0001);
            chk("halt_state", 16'(proc_state), 16'(PSPC_HALTED));
            handler_started = 1'b1;
            ext.irq(IRQ_NMI_LEVEL);
            cyc(4);
            handler_started = 1'b0;
            ext.irq(3'h0);
            chk("halt_stays", 16'(proc_state), 16'(PSPC_HALTED));
            ext.set_reset(1'b1);
            cyc(2);
            ext.set_reset(1'b0);
            finish_exc;
        end
        $display("test halt done");
    endtask
    initial begin
        t_reset;
        t_priv;
        t_internal;
        t_stop;
        t_lowpower;
        t_halt;
        report_and_stop;
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        #(25 * 5000);
        miscompares++;
        report_and_stop;
    end
endmodule
bind pspc_core pspc_core_sva chk (.*);
